//--- logic/host_port_pkg.sv
// constants and carrier types for the multiplexed host bus port
// How it works
// - address is captured when the latch strobe falls, held for the cycle
// - write data is captured when the write strobe rises
// - read data is driven in the later part of the read-low interval
// - shared-line drivers release on the first clock edge after the read strobe rises
// - with select high the address still latches but no access happens
// - output buffers are enabled only if the read strobe was low at the previous clock edge
package host_port_pkg;
  localparam int unsigned data_w = 8;
  localparam int unsigned clk_mhz = 20;
  // width of the read wait counter and the longest delay it can serve
  localparam int unsigned cnt_w = 8;
  localparam int unsigned delay_max = (1 << cnt_w) - 1;
  // delay from read strobe low to data driven, ns
  localparam int unsigned read_delay_ns = 100;
  localparam int unsigned read_delay_cyc =
    (read_delay_ns * clk_mhz + 999) / 1000;
  localparam logic [data_w-1:0] addr_rst = 8'h00;
  localparam logic [data_w-1:0] data_rst = 8'h00;

  typedef struct packed {
    logic ale;
    logic sel_n;
    logic rd_n;
    logic wr_n;
  } strobes_t;

  typedef struct packed {
    logic [data_w-1:0] addr;
    logic [data_w-1:0] data;
  } access_t;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_wait = 2'b01,
    st_drive = 2'b11
  } read_state_t;
endpackage

//--- logic/edge_detect.sv
// registered edge detector for host strobes
`timescale 1ns/1ps
`default_nettype none
module edge_detect (
  input wire logic clk,
  input wire logic rst,
  input wire logic level,
  input wire logic rst_val,
  output logic rise,
  output logic fall
);
  logic prev_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= level;
    end
  end
  // rst_val is the idle level so no false edge after reset release
  logic seen_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seen_ff <= 1'b0;
    end else begin
      seen_ff <= 1'b1;
    end
  end
  logic prev;
  assign prev = seen_ff ? prev_ff : rst_val;
  assign rise = level & ~prev;
  assign fall = ~level & prev;
endmodule // edge_detect
`default_nettype wire

//--- logic/multiplexed_host_bus_port.sv
// device end of the multiplexed address/data host port
`timescale 1ns/1ps
`default_nettype none
module multiplexed_host_bus_port #(
  parameter int unsigned read_delay = host_port_pkg::read_delay_cyc
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ale,
  input wire logic sel_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [host_port_pkg::data_w-1:0] shared_addr_data_lines_i,
  output logic [host_port_pkg::data_w-1:0] shared_addr_data_lines_o,
  output logic shared_addr_data_lines_oe,
  output logic [host_port_pkg::data_w-1:0] reg_addr,
  output logic reg_wr,
  output logic [host_port_pkg::data_w-1:0] reg_wdata,
  output logic reg_rd,
  input wire logic [host_port_pkg::data_w-1:0] reg_rdata
);
  // refuse delays the wait counter cannot reach
  if (read_delay < 1 || read_delay > host_port_pkg::delay_max) begin : g_bad_delay
    $error("read_delay out of range");
  end
  // count value at which waiting ends and driving starts
  localparam int unsigned last_int = read_delay - 1;
  localparam logic [host_port_pkg::cnt_w-1:0] last_cnt = last_int[host_port_pkg::cnt_w-1:0];

  ////////////////////////////////////////////////////////////////////////
  host_port_pkg::strobes_t strb;
  assign strb = '{ale: ale, sel_n: sel_n, rd_n: rd_n, wr_n: wr_n};
  logic ale_fall;
  logic wr_rise;
  logic rd_fall;
  edge_detect ale_ed (.clk(clk), .rst(rst), .level(strb.ale), .rst_val(1'b0),
    .rise(), .fall(ale_fall));
  edge_detect wr_ed (.clk(clk), .rst(rst), .level(strb.wr_n), .rst_val(1'b1),
    .rise(wr_rise), .fall());
  edge_detect rd_ed (.clk(clk), .rst(rst), .level(strb.rd_n), .rst_val(1'b1),
    .rise(), .fall(rd_fall));

  ////////////////////////////////////////////////////////////////////////
  // address latch, independent of select
  host_port_pkg::access_t acc_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_ff.addr <= host_port_pkg::addr_rst;
    end else if (ale_fall) begin
      acc_ff.addr <= shared_addr_data_lines_i;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_ff.data <= host_port_pkg::data_rst;
    end else if (wr_rise && !strb.sel_n) begin
      acc_ff.data <= shared_addr_data_lines_i;
    end
  end
  assign reg_addr = acc_ff.addr;
  assign reg_wdata = acc_ff.data;

  ////////////////////////////////////////////////////////////////////////
  // write pulse registered on the same edge that captures the data
  logic reg_wr_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_wr_ff <= 1'b0;
    end else begin
      reg_wr_ff <= wr_rise & ~strb.sel_n;
    end
  end
  assign reg_wr = reg_wr_ff;

  ////////////////////////////////////////////////////////////////////////
  // read sequencing
  host_port_pkg::read_state_t state_ff;
  host_port_pkg::read_state_t nxt_state;
  // wait counter runs only while a read waits for its drive point
  logic [host_port_pkg::cnt_w-1:0] cnt_ff;
  // a read is honoured only while selected, not writing and past the address phase
  logic rd_ok;
  assign rd_ok = ~strb.rd_n & ~strb.sel_n & strb.wr_n & ~strb.ale;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      host_port_pkg::st_idle: begin
        if (rd_fall && rd_ok) begin
          nxt_state = host_port_pkg::st_wait;
        end
      end
      host_port_pkg::st_wait: begin
        if (!rd_ok) begin
          nxt_state = host_port_pkg::st_idle;
        end else if (cnt_ff == last_cnt) begin
          nxt_state = host_port_pkg::st_drive;
        end
      end
      host_port_pkg::st_drive: begin
        if (!rd_ok) begin
          nxt_state = host_port_pkg::st_idle;
        end
      end
      default: begin
        nxt_state = host_port_pkg::st_idle;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= host_port_pkg::st_idle;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= '0;
    end else if (state_ff == host_port_pkg::st_wait) begin
      cnt_ff <= cnt_ff + 1'b1;
    end else begin
      cnt_ff <= '0;
    end
  end

  logic reg_rd_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rd_ff <= 1'b0;
    end else begin
      reg_rd_ff <= rd_fall & rd_ok;
    end
  end
  assign reg_rd = reg_rd_ff;

  ////////////////////////////////////////////////////////////////////////
  // next-state decode shared by the enable and the data register
  function automatic logic is_drive(input host_port_pkg::read_state_t st);
    return st == host_port_pkg::st_drive;
  endfunction

  // output drivers; enable drops combinationally-free on the next edge
  logic oe_ff;
  logic [host_port_pkg::data_w-1:0] dout_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oe_ff <= 1'b0;
    end else begin
      oe_ff <= is_drive(nxt_state) & rd_ok;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dout_ff <= host_port_pkg::data_rst;
    end else if (is_drive(nxt_state)) begin
      dout_ff <= reg_rdata;
    end
  end
  assign shared_addr_data_lines_o = dout_ff;
  assign shared_addr_data_lines_oe = oe_ff;

  ////////////////////////////////////////////////////////////////////////
  sequence rd_start_s;
    rd_fall && rd_ok;
  endsequence
  sequence rd_held_s;
    rd_ok [*2];
  endsequence

  // drive window
  no_drive_sel_a: assert property (@(posedge clk) disable iff (rst)
    strb.sel_n |=> !oe_ff) else $error("drive while deselected");
  no_drive_wr_a: assert property (@(posedge clk) disable iff (rst)
    !strb.wr_n |=> !oe_ff) else $error("drive during write");
  release_rd_a: assert property (@(posedge clk) disable iff (rst)
    strb.rd_n |=> !oe_ff) else $error("bus not released");
  oe_only_rd_a: assert property (@(posedge clk) disable iff (rst)
    oe_ff |-> !$past(strb.rd_n)) else $error("drive without read");
  no_drive_ale_a: assert property (@(posedge clk) disable iff (rst)
    strb.ale |=> !oe_ff) else $error("drive during address phase");
  idle_no_drive_a: assert property (@(posedge clk) disable iff (rst)
    state_ff == host_port_pkg::st_idle |-> !oe_ff) else $error("drive while idle");
  late_drive_a: assert property (@(posedge clk) disable iff (rst)
    rd_start_s |=> !oe_ff) else $error("drive too early");
  drive_comes_a: assert property (@(posedge clk) disable iff (rst)
    rd_start_s ##1 rd_held_s |-> ##[0:255] (oe_ff || !rd_ok))
    else $error("read data never driven");
  drive_stays_a: assert property (@(posedge clk) disable iff (rst)
    oe_ff && rd_ok |=> oe_ff) else $error("drive dropped during read");
  drive_data_a: assert property (@(posedge clk) disable iff (rst)
    is_drive(nxt_state) |=> shared_addr_data_lines_o == $past(reg_rdata))
    else $error("read data not driven");
  wait_bound_a: assert property (@(posedge clk) disable iff (rst)
    state_ff == host_port_pkg::st_wait |-> cnt_ff <= last_cnt) else $error("wait overrun");

  // address and write side
  addr_latch_a: assert property (@(posedge clk) disable iff (rst)
    ale_fall |=> reg_addr == $past(shared_addr_data_lines_i))
    else $error("address not latched");
  addr_hold_a: assert property (@(posedge clk) disable iff (rst)
    !ale_fall |=> $stable(reg_addr)) else $error("address changed");
  wr_capture_a: assert property (@(posedge clk) disable iff (rst)
    wr_rise && !strb.sel_n |=> reg_wr && reg_wdata == $past(shared_addr_data_lines_i))
    else $error("write data not captured");
  wdata_hold_a: assert property (@(posedge clk) disable iff (rst)
    !(wr_rise && !strb.sel_n) |=> $stable(reg_wdata)) else $error("write data changed");
  wr_single_a: assert property (@(posedge clk) disable iff (rst)
    reg_wr |=> !reg_wr) else $error("write pulse too long");

  // access pulses
  no_access_a: assert property (@(posedge clk) disable iff (rst)
    strb.sel_n |=> !reg_wr && !reg_rd) else $error("access while deselected");
  rd_pulse_a: assert property (@(posedge clk) disable iff (rst)
    rd_start_s |=> reg_rd) else $error("read pulse missing");
  rd_single_a: assert property (@(posedge clk) disable iff (rst)
    reg_rd |=> !reg_rd) else $error("read pulse too long");
endmodule // multiplexed_host_bus_port
`default_nettype wire

//--- testbench/host_model.sv
// host bus controller model for the multiplexed port
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk,
  input wire logic [7:0] dev_o,
  input wire logic dev_oe,
  output logic ale,
  output logic sel_n,
  output logic rd_n,
  output logic wr_n,
  output logic [7:0] bus
);
  logic h_oe;
  logic [7:0] h_val;
  // released lines show the inverse of the last value
  assign bus = dev_oe ? dev_o : (h_oe ? h_val : ~h_val);
  initial begin
    ale = 1'b0;
    sel_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    h_oe = 1'b0;
    h_val = 8'h00;
  end
  // one bus cycle: address phase, then read or write held for hold plus one cycles
  task automatic cyc(input logic [7:0] a, input logic s, input logic w,
                     input logic [7:0] d, input int hold, output logic [7:0] q);
    @(posedge clk);
    ale <= 1'b1;
    h_oe <= 1'b1;
    h_val <= a;
    @(posedge clk);
    ale <= 1'b0;
    sel_n <= s;
    @(posedge clk);
    h_oe <= w;
    h_val <= d;
    rd_n <= w;
    wr_n <= !w;
    repeat (hold) @(posedge clk);
    @(negedge clk);
    q = bus;
    @(posedge clk);
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    repeat (2) @(posedge clk);
    sel_n <= 1'b1;
    h_oe <= 1'b0;
  endtask
endmodule // host_model
`default_nettype wire

//--- testbench/multiplexed_host_bus_port_test.sv
// self-checking bench for the multiplexed host bus port
`timescale 1ns/1ps
`default_nettype none
module multiplexed_host_bus_port_test;
  typedef struct packed {logic [7:0] a; logic s; logic w; logic [7:0] d; logic [7:0] e;} row_t;
  logic clk, rst, ale, sel_n, rd_n, wr_n, oe, rd_p, wr_p, saw_oe;
  logic [7:0] bus, dev_o, addr, wdata, rdata, q, wr_cnt, rd_cnt, exp_wc, exp_rc;
  int err_count, n_tests, cycles;
  // address, select, write, data, then wdata expected after a write or q after a read;
  // a deselected read sees the released lines, the inverse of the host's last data
  row_t rows [4] = '{'{8'h3c, 1'b0, 1'b1, 8'ha5, 8'ha5}, '{8'h3c, 1'b0, 1'b0, 8'h96, 8'h96},
                     '{8'hc3, 1'b1, 1'b1, 8'h0f, 8'ha5}, '{8'hff, 1'b1, 1'b0, 8'h81, 8'h7e}};
  host_model host_u (.clk(clk), .dev_o(dev_o), .dev_oe(oe), .ale(ale), .sel_n(sel_n),
    .rd_n(rd_n), .wr_n(wr_n), .bus(bus));
  multiplexed_host_bus_port #(.read_delay(2)) dut_u (.clk(clk), .rst(rst), .ale(ale),
    .sel_n(sel_n), .rd_n(rd_n), .wr_n(wr_n), .shared_addr_data_lines_i(bus),
    .shared_addr_data_lines_o(dev_o), .shared_addr_data_lines_oe(oe), .reg_addr(addr),
    .reg_wr(wr_p), .reg_wdata(wdata), .reg_rd(rd_p), .reg_rdata(rdata));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    {wr_cnt, rd_cnt, saw_oe} = '0;
    cycles = 0;
  end
  always @(posedge clk) begin
    cycles++;
    if (wr_p === 1'b1) wr_cnt <= wr_cnt + 8'h01;
    if (rd_p === 1'b1) rd_cnt <= rd_cnt + 8'h01;
    if (oe === 1'b1) saw_oe <= 1'b1;
    if (cycles == 3000) begin
      err_count++;
      finish_test();
    end
  end
  // drive only while selected, with the write strobe high and no address phase
  always @(negedge clk) begin
    if (oe === 1'b1 && (wr_n !== 1'b1 || ale !== 1'b0 || sel_n !== 1'b0)) begin
      check(8'h01, 8'h00);
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    rdata = 8'h00;
    {exp_wc, exp_rc} = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      @(posedge clk);
      rdata <= rows[i].d;
      host_u.cyc(rows[i].a, rows[i].s, rows[i].w, rows[i].d, 5, q);
      @(negedge clk);
      check(addr, rows[i].a);
      if (rows[i].w) begin
        exp_wc += {7'h0, !rows[i].s};
        check(wdata, rows[i].e);
        check(wr_cnt, exp_wc);
      end else begin
        exp_rc += {7'h0, !rows[i].s};
        check(q, rows[i].e);
        check(rd_cnt, exp_rc);
      end
      check({7'h0, oe}, 8'h00);
    end
    // read released before the late drive point: lines never driven
    saw_oe = 1'b0;
    host_u.cyc(8'h55, 1'b0, 1'b0, 8'h77, 0, q);
    @(negedge clk);
    check({7'h0, saw_oe}, 8'h00);
    check(q, 8'h88);
    check(rd_cnt, exp_rc + 8'h01);
    // second reset in mid-run clears latched state
    @(posedge clk);
    rst <= 1'b1;
    @(negedge clk);
    check(addr, 8'h00);
    check(wdata, 8'h00);
    check({7'h0, oe}, 8'h00);
    @(posedge clk);
    rst <= 1'b0;
    // first access after release: address and write data land again
    host_u.cyc(8'h5a, 1'b0, 1'b1, 8'hc3, 1, q);
    @(negedge clk);
    check(addr, 8'h5a);
    check(wdata, 8'hc3);
    check(wr_cnt, exp_wc + 8'h01);
    finish_test();
  end
endmodule // multiplexed_host_bus_port_test
`default_nettype wire
